// ==== inc/gio_regs.vh ====
// register offsets, field positions, codes and reset values of the gpio logic cell
`ifndef GIO_REGS_VH
`define GIO_REGS_VH

`define GIO_ADDR_W        8
`define GIO_CTRL_ADDR     8'h00
`define GIO_DONE_ADDR     8'h04
`define GIO_STAT_ADDR     8'h08

`define GIO_MODE_LSB      0
`define GIO_MODE_MSB      1
`define GIO_USED_BIT      2
`define GIO_DOUBLE_EDGE_IO_BIT      3
`define GIO_IN_REG_BIT    4
`define GIO_OUT_REG_BIT   5
`define GIO_OE_REG_BIT    6
`define GIO_IN_EDGE_BIT   7
`define GIO_OUT_EDGE_BIT  8
`define GIO_OE_EDGE_BIT   9
`define GIO_INVERT_BIT    10
`define GIO_RESYNC_BIT    11
`define GIO_PULL_LSB      12
`define GIO_PULL_MSB      13
`define GIO_SCHMITT_BIT   14
`define GIO_DRIVE_LSB     15
`define GIO_DRIVE_MSB     16
`define GIO_SLEW_BIT      17
`define GIO_ALT_BIT       18
`define GIO_CTRL_MASK     32'h0007_ffff
`define GIO_CTRL_RST      32'h0000_1000

`define GIO_MODE_INPUT    2'h0
`define GIO_MODE_OUTPUT   2'h1
`define GIO_MODE_BIDIR    2'h2
`define GIO_MODE_CLKOUT   2'h3

`define GIO_PULL_NONE     2'h0
`define GIO_PULL_UP       2'h1
`define GIO_PULL_DOWN     2'h2

`define GIO_EDGE_RISE     1'b0
`define GIO_EDGE_FALL     1'b1

`define GIO_STAT_PAD_BIT  0
`define GIO_STAT_IN_LSB   1
`define GIO_STAT_IN_MSB   2
`define GIO_STAT_DONE_BIT 3
`define GIO_STAT_OE_BIT   4
`define GIO_STAT_OUT_BIT  5

`endif

// ==== verilog/gio_sync.v ====
// two-flop synchroniser for a group of asynchronous levels
module gio_sync #(
	parameter WIDTH = 4
) (
	input  wire             clk_sys,
	input  wire             reset_n,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta_q;
			reg sync_q;
			always @(posedge clk_sys) begin
				if (!reset_n) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end else begin
					meta_q <= async_in[i];
					sync_q <= meta_q;
				end
			end
			assign sync_out[i] = sync_q;
		end
	endgenerate
endmodule

// ==== verilog/gio_edge_reg.v ====
// data register loaded on a chosen edge of a sampled clock
module gio_edge_reg (
	input  wire clk_sys,
	input  wire reset_n,
	input  wire rise,
	input  wire fall,
	input  wire edge_sel,
	input  wire d,
	output wire q
);
	reg data_q;
	wire load;

	assign load = edge_sel ? fall : rise;

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			data_q <= 1'b0;
		end else if (load) begin
			data_q <= d;
		end
	end

	assign q = data_q;
endmodule

// ==== verilog/gio_io_logic_cell.v ====
// gpio logic cell: apb configuration, receive, transmit, enable and pad control
//
// Summary of operation
// [R1] input mode: receive only, optional edge register
// [R2] alternate input passes pad without register
// [R3] double-edge input: rise and fall captures
// [R4] output mode: transmit only, optional edge register
// [R5] optional inversion of output register value
// [R6] double-edge output: two registers muxed on pad
// [R7] bidir: all paths, rx and tx clocks
// [R8] bidir: independent registering and edge selects
// [R9] clock-output mode drives global clock onto pad
// [R10] enable controls driver; off means high impedance
// [R11] during configuration: tristate with pull-up
// [R12] unused pins: tristate, pull-up or optional pull-down
// [R13] selectable schmitt input and weak pulls
// [R14] four drive strengths, slew on means slow
// [R15] alternate input feeds another block directly
// [R16] double-edge bit zero rise, bit one fall
// [R17] resync delays fall sample by half period
// [R18] settings static, frozen once configuration ends
`include "gio_regs.vh"

module gio_io_logic_cell (
	input  wire        clk_sys,
	input  wire        reset_n,
	input  wire [7:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        rx_clock,
	input  wire        tx_clock,
	input  wire        global_clock_line,
	input  wire [1:0]  core_out,
	input  wire        core_oe,
	output wire [1:0]  core_in,
	output wire        alternate_input,
	input  wire        pad_in,
	output wire        pad_out,
	output wire        pad_oe_n,
	output wire        pad_pull_up,
	output wire        pad_pull_down,
	output wire        pad_schmitt,
	output wire [1:0]  pad_drive,
	output wire        pad_slew_slow
);
	reg  [31:0] ctrl_q;
	reg         done_q;
	reg         rx_clk_p_q;
	reg         tx_clk_p_q;
	reg  [1:0]  core_in_q;
	reg         pad_out_q;
	reg         pad_oe_n_q;
	reg         pull_up_q;
	reg         pull_down_q;
	reg         schmitt_q;
	reg  [1:0]  drive_q;
	reg         slew_q;

	wire [3:0]  sync_in;
	wire [3:0]  sync_out;
	wire        pad_s;
	wire        rx_clk_s;
	wire        tx_clk_s;
	wire        global_clock_line_s;
	wire        rx_rise;
	wire        rx_fall;
	wire        tx_rise;
	wire        tx_fall;

	wire [1:0]  mode;
	wire        used;
	wire        double_edge_io;
	wire        in_reg;
	wire        out_reg;
	wire        oe_reg;
	wire        in_edge;
	wire        out_edge;
	wire        oe_edge;
	wire        invert;
	wire        resync;
	wire [1:0]  pull;
	wire        alt_en;

	wire        in_q;
	wire        in_r_q;
	wire        in_f_q;
	wire        in_rs_q;
	wire        out_q;
	wire        out_r_q;
	wire        out_f_q;
	wire        oe_q;
	wire [7:0]  er_sel;
	wire [7:0]  er_d;
	wire [7:0]  er_q;

	wire        acc;
	wire        wr;
	wire        hit_ctrl;
	wire        hit_done;
	wire        hit_stat;
	wire        mapped;

	reg  [1:0]  core_in_d;
	reg         pad_out_d;
	reg         oe_d;
	reg         pull_up_d;
	reg         pull_down_d;
	reg         tx_val;

	// pad and clock pins are asynchronous to clk_sys
	assign sync_in = {global_clock_line, tx_clock, rx_clock, pad_in};

	gio_sync #(
		.WIDTH(4)
	) u_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.async_in(sync_in),
		.sync_out(sync_out)
	);

	assign pad_s    = sync_out[0];
	assign rx_clk_s = sync_out[1];
	assign tx_clk_s = sync_out[2];
	assign global_clock_line_s   = sync_out[3];

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			rx_clk_p_q <= 1'b0;
			tx_clk_p_q <= 1'b0;
		end else begin
			rx_clk_p_q <= rx_clk_s;
			tx_clk_p_q <= tx_clk_s;
		end
	end

	assign rx_rise = rx_clk_s & ~rx_clk_p_q;
	assign rx_fall = ~rx_clk_s & rx_clk_p_q;
	assign tx_rise = tx_clk_s & ~tx_clk_p_q;
	assign tx_fall = ~tx_clk_s & tx_clk_p_q;

	// configuration fields
	assign mode     = ctrl_q[`GIO_MODE_MSB:`GIO_MODE_LSB];
	assign used     = ctrl_q[`GIO_USED_BIT];
	assign double_edge_io     = ctrl_q[`GIO_DOUBLE_EDGE_IO_BIT];
	assign in_reg   = ctrl_q[`GIO_IN_REG_BIT];
	assign out_reg  = ctrl_q[`GIO_OUT_REG_BIT];
	assign oe_reg   = ctrl_q[`GIO_OE_REG_BIT];
	assign in_edge  = ctrl_q[`GIO_IN_EDGE_BIT];
	assign out_edge = ctrl_q[`GIO_OUT_EDGE_BIT];
	assign oe_edge  = ctrl_q[`GIO_OE_EDGE_BIT];
	assign invert   = ctrl_q[`GIO_INVERT_BIT];
	assign resync   = ctrl_q[`GIO_RESYNC_BIT];
	assign pull     = ctrl_q[`GIO_PULL_MSB:`GIO_PULL_LSB];
	assign alt_en   = ctrl_q[`GIO_ALT_BIT];

	// apb slave, zero wait states
	assign acc      = psel & penable;
	assign wr       = acc & pwrite;
	assign hit_ctrl = (paddr == `GIO_CTRL_ADDR);
	assign hit_done = (paddr == `GIO_DONE_ADDR);
	assign hit_stat = (paddr == `GIO_STAT_ADDR);
	assign mapped   = hit_ctrl | hit_done | hit_stat;
	assign pready   = 1'b1;
	assign pslverr  = acc & ~mapped;

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			ctrl_q <= `GIO_CTRL_RST;
			done_q <= 1'b0;
		end else if (wr && !done_q) begin
			if (hit_ctrl) begin
				ctrl_q <= pwdata & `GIO_CTRL_MASK; // R18
			end
			if (hit_done) begin
				done_q <= pwdata[0]; // R18
			end
		end
	end

	always @* begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite) begin
			if (hit_ctrl) begin
				prdata = ctrl_q;
			end else if (hit_done) begin
				prdata = {31'h0000_0000, done_q};
			end else if (hit_stat) begin
				prdata[`GIO_STAT_PAD_BIT] = pad_s;
				prdata[`GIO_STAT_IN_MSB:`GIO_STAT_IN_LSB] = core_in_q;
				prdata[`GIO_STAT_DONE_BIT] = done_q;
				prdata[`GIO_STAT_OE_BIT] = ~pad_oe_n_q;
				prdata[`GIO_STAT_OUT_BIT] = pad_out_q;
			end
		end
	end

	// edge registers: 0 rx, 1 rx rise, 2 rx fall, 3 resync, 4 tx, 5 tx rise, 6 tx fall, 7 oe
	assign er_sel = {oe_edge, `GIO_EDGE_FALL, `GIO_EDGE_RISE, out_edge,
		`GIO_EDGE_RISE, `GIO_EDGE_FALL, `GIO_EDGE_RISE, in_edge}; // R1 R3 R4 R6 R8
	assign er_d   = {core_oe, core_out[1], core_out[0], core_out[0],
		in_f_q, pad_s, pad_s, pad_s}; // R7 R16 R17
	assign {oe_q, out_f_q, out_r_q, out_q, in_rs_q, in_f_q, in_r_q, in_q} = er_q;

	genvar k;
	generate
		for (k = 0; k < 8; k = k + 1) begin : g_edge
			// entries 0 to 3 follow the rx clock, 4 to 7 the tx clock
			gio_edge_reg u_reg (
				.clk_sys (clk_sys),
				.reset_n (reset_n),
				.rise    ((k < 4) ? rx_rise : tx_rise),
				.fall    ((k < 4) ? rx_fall : tx_fall),
				.edge_sel(er_sel[k]),
				.d       (er_d[k]),
				.q       (er_q[k])
			);
		end
	endgenerate

	// path selection
	always @* begin
		core_in_d   = 2'h0;
		pad_out_d   = 1'b0;
		oe_d        = 1'b0;
		pull_up_d   = 1'b1;
		pull_down_d = 1'b0;
		tx_val      = 1'b0;
		if (double_edge_io) begin
			tx_val = (tx_clk_s ? out_r_q : out_f_q) ^ invert; // R6 R16 R5
		end else if (out_reg) begin
			tx_val = out_q ^ invert; // R4 R5
		end else begin
			tx_val = core_out[0];
		end
		if (done_q) begin
			if (used) begin
				case (mode)
					`GIO_MODE_INPUT: begin
						oe_d = 1'b0; // R1
					end
					`GIO_MODE_OUTPUT: begin
						oe_d      = 1'b1; // R4
						pad_out_d = tx_val;
					end
					`GIO_MODE_BIDIR: begin
						oe_d      = oe_reg ? oe_q : core_oe; // R7 R10
						pad_out_d = tx_val;
					end
					`GIO_MODE_CLKOUT: begin
						oe_d      = 1'b1;
						pad_out_d = global_clock_line_s; // R9
					end
					default: begin
						oe_d = 1'b0;
					end
				endcase
				if (mode == `GIO_MODE_INPUT || mode == `GIO_MODE_BIDIR) begin
					if (double_edge_io) begin
						core_in_d = {resync ? in_rs_q : in_f_q, in_r_q}; // R3 R16 R17
					end else begin
						core_in_d = {1'b0, in_reg ? in_q : pad_s}; // R1 R8
					end
				end
				pull_up_d   = (pull == `GIO_PULL_UP); // R13
				pull_down_d = (pull == `GIO_PULL_DOWN); // R13
			end else begin
				pull_up_d   = (pull != `GIO_PULL_DOWN); // R12
				pull_down_d = (pull == `GIO_PULL_DOWN); // R12
			end
		end
	end

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			core_in_q   <= 2'h0;
			pad_out_q   <= 1'b0;
			pad_oe_n_q  <= 1'b1;
			pull_up_q   <= 1'b1;
			pull_down_q <= 1'b0;
			schmitt_q   <= 1'b0;
			drive_q     <= 2'h0;
			slew_q      <= 1'b0;
		end else begin
			core_in_q   <= core_in_d;
			pad_out_q   <= pad_out_d & oe_d;
			pad_oe_n_q  <= ~oe_d; // R10 R11
			pull_up_q   <= pull_up_d; // R11
			pull_down_q <= pull_down_d;
			schmitt_q   <= done_q & ctrl_q[`GIO_SCHMITT_BIT]; // R13
			drive_q     <= done_q ? ctrl_q[`GIO_DRIVE_MSB:`GIO_DRIVE_LSB] : 2'h0; // R14
			slew_q      <= done_q & ctrl_q[`GIO_SLEW_BIT]; // R14
		end
	end

	// unregistered alternate path to neighbouring blocks
	assign alternate_input = done_q & used & alt_en & (mode == `GIO_MODE_INPUT) & pad_s; // R2 R15

	assign core_in       = core_in_q;
	assign pad_out       = pad_out_q;
	assign pad_oe_n      = pad_oe_n_q;
	assign pad_pull_up   = pull_up_q;
	assign pad_pull_down = pull_down_q;
	assign pad_schmitt   = schmitt_q;
	assign pad_drive     = drive_q;
	assign pad_slew_slow = slew_q;
endmodule

// ==== bench/gio_pad_model.sv ====
// board side of the pad: driver, external source, weak pulls
module gio_pad_model (
	input	wire logic	clk_sys,
	input	wire logic	pad_out,
	input	wire logic	pad_oe_n,
	input	wire logic	pad_pull_up,
	input	wire logic	pad_pull_down,
	input	wire logic	ext_en,
	input	wire logic	ext_val,
	output	logic		pad_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic	flt_q = 1'b0;
	// an undriven, unpulled pad wanders every cycle
	always @(posedge clk_sys) flt_q <= ~flt_q;
	always_comb begin
		if (!pad_oe_n) pad_in = pad_out;
		else if (ext_en) pad_in = ext_val;
		else if (pad_pull_up) pad_in = 1'b1;
		else if (pad_pull_down) pad_in = 1'b0;
		else pad_in = flt_q;
	end
endmodule

// ==== bench/gio_cell_props.sv ====
// assertions and covers on the gpio logic cell ports
module gio_cell_props (
	input	wire logic		clk_sys,
	input	wire logic		reset_n,
	input	wire logic [7:0]	paddr,
	input	wire logic		psel,
	input	wire logic		penable,
	input	wire logic		pwrite,
	input	wire logic [31:0]	pwdata,
	input	wire logic		global_clock_line,
	input	wire logic [1:0]	core_out,
	input	wire logic [1:0]	core_in,
	input	wire logic		alternate_input,
	input	wire logic		pad_in,
	input	wire logic		pad_out,
	input	wire logic		pad_oe_n,
	input	wire logic		pad_pull_up,
	input	wire logic		pad_pull_down
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic [18:0]	ctrl_q;
	logic		done_q;
	// shadow of the settings, frozen once configuration ends
	wire acc = psel && penable && pwrite && !done_q;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ctrl_q <= 19'h01000;
			done_q <= 1'b0;
		end else if (acc && paddr == 8'h00) begin
			ctrl_q <= pwdata[18:0];
		end else if (acc && paddr == 8'h04) begin
			done_q <= pwdata[0];
		end
	end
	wire used = done_q && ctrl_q[2];
	wire rx_plain = used && ctrl_q[1:0] == 2'h0 && !ctrl_q[3] && !ctrl_q[4];
	wire tx_plain = used && ctrl_q[1:0] == 2'h1 && !ctrl_q[3] && !ctrl_q[5];
	a_config_tristate: assert property (!done_q |=> pad_oe_n && pad_pull_up && !pad_pull_down)
		else $error("pad not parked during configuration");
	a_input_no_drive: assert property (used && ctrl_q[1:0] == 2'h0 |=> pad_oe_n)
		else $error("input mode drives pad");
	a_tx_plain_path: assert property (tx_plain |=> !pad_oe_n && pad_out == $past(core_out[0]))
		else $error("plain transmit path wrong");
	a_rx_plain_path: assert property (rx_plain |-> ##2 core_in[0] == $past(pad_in, 3))
		else $error("plain receive path wrong");
	a_clock_out_path: assert property (used && ctrl_q[1:0] == 2'h3
		|-> ##2 !pad_oe_n && pad_out == $past(global_clock_line, 3))
		else $error("clock output path wrong");
	a_unused_pull_down: assert property (done_q && !ctrl_q[2] && ctrl_q[13:12] == 2'h2
		|=> pad_oe_n && pad_pull_down && !pad_pull_up)
		else $error("unused pin pull wrong");
	a_pulls_exclusive: assert property (!(pad_pull_up && pad_pull_down))
		else $error("both pulls on");
	a_off_output_low: assert property (pad_oe_n |-> !pad_out)
		else $error("value driven while off");
	a_alt_pass: assert property (alternate_input |-> $past(pad_in, 2))
		else $error("alternate input not from pad");
	c_tx_plain: cover property (tx_plain);
	c_rx_plain: cover property (rx_plain);
	c_clock_out: cover property (used && ctrl_q[1:0] == 2'h3);
endmodule

bind gio_io_logic_cell gio_cell_props gio_cell_props_inst (.clk_sys, .reset_n, .paddr, .psel,
	.penable, .pwrite, .pwdata, .global_clock_line, .core_out, .core_in, .alternate_input,
	.pad_in, .pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_down);

// ==== bench/testbench.sv ====
// self-checking bench for the gpio logic cell
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic		clk_sys = 0;
	logic		reset_n = 0;
	logic [7:0]	paddr = 0;
	logic		psel = 0;
	logic		penable = 0;
	logic		pwrite = 0;
	logic [31:0]	pwdata = 0;
	logic		rx_clock = 0;
	logic		tx_clock = 0;
	logic		global_clock_line = 0;
	logic [1:0]	core_out = 0;
	logic		core_oe = 0;
	logic		ext_en = 0;
	logic		ext_val = 0;
	logic [31:0]	prdata, rd;
	logic [1:0]	core_in, pad_drive;
	logic		pready, pslverr, alternate_input, pad_in, pad_out, pad_oe_n, err;
	logic		pad_pull_up, pad_pull_down, pad_schmitt, pad_slew_slow;
	int		error_cnt = 0;
	int		cmp_count = 0;

	gio_io_logic_cell gio_io_logic_cell_inst (.clk_sys, .reset_n, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .rx_clock, .tx_clock,
		.global_clock_line, .core_out, .core_oe, .core_in, .alternate_input, .pad_in,
		.pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_down, .pad_schmitt, .pad_drive,
		.pad_slew_slow);
	gio_pad_model gio_pad_model_inst (.clk_sys, .pad_out, .pad_oe_n, .pad_pull_up,
		.pad_pull_down, .ext_en, .ext_val, .pad_in);

	always #25 clk_sys = ~clk_sys;

	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h want %h", $time, s, e);
		end
	endtask
	// waits n edges, then settles at the falling edge for sampling
	task automatic w(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
		@(posedge clk_sys) psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge clk_sys) penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rst;
		@(posedge clk_sys) reset_n <= 1'b0;
		{core_out, core_oe, ext_en, rx_clock, tx_clock} <= '0;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
	endtask
	task automatic cfg(input logic [31:0] c);
		rst;
		apb(8'h00, 1'b1, c);
		apb(8'h04, 1'b1, 32'h1);
		w(2);
	endtask
	task automatic pad(input logic v);
		@(posedge clk_sys) ext_en <= 1'b1;
		ext_val <= v;
		w(4);
	endtask
	task automatic rxc(input logic v);
		@(posedge clk_sys) rx_clock <= v;
		w(6);
	endtask
	task automatic txc(input logic v);
		@(posedge clk_sys) tx_clock <= v;
		w(6);
	endtask

	task automatic t_regs;
		rst;
		apb(8'h00, 1'b0, 0);
		chk(rd, 32'h1000);
		chk({pad_oe_n, pad_pull_up, pad_pull_down}, 3'b110);
		apb(8'h0c, 1'b1, 32'h1);
		chk(err, 1'b1);
		apb(8'h08, 1'b0, 0);
		chk(rd[3:0], 4'h1);
		$display("t_regs done");
	endtask
	task automatic t_out;
		cfg(32'h38005);
		@(posedge clk_sys) core_out <= 2'h1;
		w(2);
		chk({pad_oe_n, pad_out, pad_drive, pad_slew_slow}, 5'b01111);
		apb(8'h00, 1'b1, 0);
		apb(8'h00, 1'b0, 0);
		chk(rd, 32'h38005);
		$display("t_out done");
	endtask
	task automatic t_in;
		cfg(32'h94);
		pad(1'b1);
		rxc(1'b1);
		chk(core_in[0], 1'b0);
		rxc(1'b0);
		chk({pad_oe_n, core_in[0]}, 2'b11);
		cfg(32'hc);
		pad(1'b1);
		rxc(1'b1);
		pad(1'b0);
		rxc(1'b0);
		chk(core_in, 2'h1);
		$display("t_in done");
	endtask
	task automatic t_ddr_out;
		for (int i = 0; i < 2; i++) begin
			cfg(32'hd | (i << 10));
			@(posedge clk_sys) core_out <= 2'h1;
			txc(1'b1);
			chk(pad_out, 1'b1 ^ i[0]);
			txc(1'b0);
			chk(pad_out, i[0]);
		end
		$display("t_ddr_out done");
	endtask
	task automatic t_misc;
		cfg(32'h6);
		@(posedge clk_sys) core_oe <= 1'b1;
		core_out <= 2'h1;
		w(5);
		chk({pad_oe_n, pad_out, core_in[0]}, 3'b011);
		@(posedge clk_sys) core_oe <= 1'b0;
		w(3);
		chk({pad_oe_n, pad_out}, 2'b10);
		cfg(32'h2000);
		chk({pad_oe_n, pad_pull_up, pad_pull_down}, 3'b101);
		cfg(32'h7);
		repeat (2) begin
			@(posedge clk_sys) global_clock_line <= ~global_clock_line;
			w(4);
			chk(pad_out, global_clock_line);
		end
		cfg(32'h40004);
		pad(1'b1);
		chk(alternate_input, 1'b1);
		pad(1'b0);
		chk(alternate_input, 1'b0);
		$display("t_misc done");
	endtask
	task automatic t_paths;
		cfg(32'h5566);
		@(posedge clk_sys) core_oe <= 1'b1;
		core_out <= 2'h1;
		w(3);
		chk({pad_oe_n, pad_out, pad_schmitt, pad_pull_up}, 4'b1011);
		txc(1'b1);
		chk({pad_oe_n, pad_out}, 2'b01);
		txc(1'b0);
		chk({pad_oe_n, pad_out}, 2'b00);
		cfg(32'h80c);
		pad(1'b0);
		rxc(1'b1);
		pad(1'b1);
		rxc(1'b0);
		chk(core_in, 2'h0);
		pad(1'b0);
		rxc(1'b1);
		chk(core_in, 2'h2);
		$display("t_paths done");
	endtask

	initial begin
		t_regs;
		t_out;
		t_in;
		t_ddr_out;
		t_misc;
		t_paths;
		complete_run;
	end
	initial begin
		#200000;
		error_cnt++;
		complete_run;
	end
endmodule
